/* snv_defs.vh */
// constants for the serial nonvolatile memory spi slave
`ifndef SNV_DEFS_VH
`define SNV_DEFS_VH

// memory geometry
`define SNV_ADDR_W        13
`define SNV_DATA_W        8
`define SNV_DEPTH         8192

// command codes, first byte after chip select falls
`define SNV_CMD_WRITE_STATUS   8'h01
`define SNV_CMD_WRITE_ARRAY    8'h02
`define SNV_CMD_READ_ARRAY     8'h03
`define SNV_CMD_WRITE_DISABLE  8'h04
`define SNV_CMD_READ_STATUS    8'h05
`define SNV_CMD_WRITE_ENABLE   8'h06

// status register field positions
`define SNV_ST_GUARD_BIT  7
`define SNV_ST_BP_HI      3
`define SNV_ST_BP_LO      2
`define SNV_ST_WEL_BIT    1

// status register reset value and writable bit mask
`define SNV_ST_RESET      8'h00
`define SNV_ST_WMASK      8'h8C

// pin synchroniser reset value: select, protect and suspend idle high
`define SNV_SYNC_RESET    5'h19

// block protection encodings
`define SNV_BP_NONE       2'h0
`define SNV_BP_QUARTER    2'h1
`define SNV_BP_HALF       2'h2
`define SNV_BP_ALL        2'h3

`endif

/* snv_mem.v */
// byte wide array with registered read data
`timescale 1ns/1ns
`default_nettype none

module snv_mem #(
  parameter ADDR_W = 13,                  // address width
  parameter DATA_W = 8,                   // word width
  parameter DEPTH  = 8192                 // number of words
) (
  input  wire              clk,           // system clock
  input  wire              wr_en,         // write strobe, one cycle
  input  wire [ADDR_W-1:0] wr_addr,       // write address
  input  wire [DATA_W-1:0] wr_data,       // write data
  input  wire [ADDR_W-1:0] rd_addr,       // read address
  output reg  [DATA_W-1:0] rd_data        // read data, one cycle late
);

  reg [DATA_W-1:0] mem [0:DEPTH-1];       // storage array

  // write and read on the same edge; read returns the old word
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // snv_mem

`default_nettype wire

/* snv_spi_slave.v */
// spi slave front end of a byte organised nonvolatile memory
`timescale 1ns/1ns
`default_nettype none
`include "snv_defs.vh"

module snv_spi_slave #(
  parameter ADDR_W = `SNV_ADDR_W,         // array address width
  parameter DEPTH  = `SNV_DEPTH           // array depth in bytes
) (
  input  wire       clk,                  // 125 MHz system clock
  input  wire       srst,                 // synchronous reset, high
  input  wire       cs_n,                 // chip select pin, low active
  input  wire       sck,                  // serial clock pin
  input  wire       si,                   // serial data in pin
  output reg        so_out,               // serial data out value
  output reg        so_oe,                // serial out drive enable
  input  wire       wp_n,                 // write protect pin, low active
  input  wire       hold_n,               // suspend pin, low active
  output wire [7:0] status_out            // status register contents
);

  // state codes of the serial machine
  localparam [2:0] ST_OP     = 3'h0;      // receiving opcode
  localparam [2:0] ST_ADDR_H = 3'h1;      // receiving high address
  localparam [2:0] ST_ADDR_L = 3'h2;      // receiving low address
  localparam [2:0] ST_WRITE  = 3'h3;      // receiving array data
  localparam [2:0] ST_READ   = 3'h4;      // returning array data
  localparam [2:0] ST_RSTAT  = 3'h5;      // returning status
  localparam [2:0] ST_WSTAT  = 3'h6;      // receiving status byte
  localparam [2:0] ST_IGNORE = 3'h7;      // dead until reselect

  // two-flop synchronisers for every pin input
  reg  [4:0] sync1_reg;                   // first stage only
  reg  [4:0] sync2_reg;                   // second stage
  reg        sck_prev_reg;                // last synced clock level
  reg        cs_prev_reg;                 // last accepted select level

  wire       cs_s   = sync2_reg[0];       // synced chip select
  wire       sck_s  = sync2_reg[1];       // synced serial clock
  wire       si_s   = sync2_reg[2];       // synced data in
  wire       wp_s   = sync2_reg[3];       // synced write protect
  wire       hold_s = sync2_reg[4];       // synced suspend

  reg  [2:0]        state_reg;            // serial machine state
  reg  [2:0]        bit_cnt_reg;          // bit within current byte
  reg  [7:0]        rx_reg;               // incoming shift register
  reg  [7:0]        tx_reg;               // outgoing shift register
  reg  [15:0]       addr_raw_reg;         // address as received
  reg  [ADDR_W-1:0] addr_reg;             // current array address
  reg  [7:0]        status_reg;           // guard and protect bits
  reg               wel_reg;              // write enable latch
  reg               mem_we;               // array write strobe
  reg  [7:0]        mem_wdata;            // array write data
  reg               so_oe_arm_reg;        // read data has started
  wire [7:0]        mem_rdata;            // array read data

  // block protection decode; bp codes cover the top of the array
  function prot_hit;
    input [1:0]        bp;
    input [ADDR_W-1:0] a;
    begin
      case (bp)
        `SNV_BP_QUARTER: prot_hit = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
        `SNV_BP_HALF:    prot_hit = a[ADDR_W-1];
        `SNV_BP_ALL:     prot_hit = 1'b1;
        default:         prot_hit = 1'b0;
      endcase
    end
  endfunction

  // suspend freezes the machine; clock edges only count when selected
  wire run      = hold_s & ~cs_s;
  wire sck_rise = run & sck_s & ~sck_prev_reg;
  wire sck_fall = run & ~sck_s & sck_prev_reg;
  // select rise is only seen while not suspended
  wire cs_rise  = hold_s & cs_s & ~cs_prev_reg;
  wire [7:0] rx_byte = {rx_reg[6:0], si_s};            // msb first
  wire byte_done = sck_rise & (bit_cnt_reg == 3'h7);   // eighth bit
  wire [1:0] bp = status_reg[`SNV_ST_BP_HI:`SNV_ST_BP_LO];
  wire sending = (state_reg == ST_READ) | (state_reg == ST_RSTAT);
  wire [7:0] out_byte = (state_reg == ST_RSTAT) ? status_out : mem_rdata;

  assign status_out = {status_reg[7:2], wel_reg, status_reg[0]};

  // pin synchronisers; first stage feeds only the second stage
  always @(posedge clk) begin
    if (srst) begin
      sync1_reg <= `SNV_SYNC_RESET;
      sync2_reg <= `SNV_SYNC_RESET;
    end else begin
      sync1_reg <= {hold_n, wp_n, si, sck, cs_n};
      sync2_reg <= sync1_reg;
    end
  end

  // main serial machine
  always @(posedge clk) begin
    if (srst) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b1;
      state_reg    <= ST_OP;
      bit_cnt_reg  <= 3'h0;
      rx_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      addr_raw_reg <= 16'h0000;
      addr_reg     <= {ADDR_W{1'b0}};
      status_reg   <= `SNV_ST_RESET;
      wel_reg      <= 1'b0;
      mem_we       <= 1'b0;
      mem_wdata    <= 8'h00;
      so_out       <= 1'b0;
      so_oe        <= 1'b0;
    end else begin
      mem_we       <= 1'b0;
      // no timeout anywhere, so a stopped clock simply keeps all state
      sck_prev_reg <= sck_s;
      // the select edge is frozen while suspended
      if (hold_s) begin
        cs_prev_reg <= cs_s;
      end
      if (cs_s && hold_s) begin
        // deselected: back to opcode, partial byte lost; a select rise
        // during suspend is held off until suspend ends
        state_reg   <= ST_OP;
        bit_cnt_reg <= 3'h0;
        so_oe       <= 1'b0;
        // an array write drops the enable latch; a finished status write is in ST_IGNORE, keeps it
        if (cs_rise && (state_reg == ST_WRITE ||
                        state_reg == ST_WSTAT)) begin
          wel_reg <= 1'b0;
        end
      end else begin
        // output floats during suspend, comes back on resume
        so_oe <= hold_s & sending & so_oe_arm_reg;
      end
      if (sck_rise) begin
        rx_reg      <= rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
      if (byte_done) begin
        case (state_reg)
          ST_OP: begin
            case (rx_byte)
              `SNV_CMD_WRITE_ENABLE: begin
                wel_reg   <= 1'b1;
                state_reg <= ST_IGNORE;
              end
              `SNV_CMD_WRITE_DISABLE: begin
                wel_reg   <= 1'b0;
                state_reg <= ST_IGNORE;
              end
              `SNV_CMD_READ_STATUS:  state_reg <= ST_RSTAT;
              `SNV_CMD_WRITE_STATUS: state_reg <= ST_WSTAT;
              `SNV_CMD_READ_ARRAY,
              `SNV_CMD_WRITE_ARRAY: begin
                state_reg <= ST_ADDR_H;
                tx_reg    <= rx_byte;                  // remember command
              end
              default: state_reg <= ST_IGNORE;
            endcase
          end
          ST_ADDR_H: begin
            addr_raw_reg[15:8] <= rx_byte;
            state_reg          <= ST_ADDR_L;
          end
          ST_ADDR_L: begin
            // top three address bits are dropped
            addr_raw_reg[7:0] <= rx_byte;
            addr_reg <= {addr_raw_reg[ADDR_W-1:8], rx_byte};
            state_reg <= (tx_reg == `SNV_CMD_READ_ARRAY) ?
                         ST_READ : ST_WRITE;
          end
          ST_WRITE: begin
            // commit at once; guarded by latch and block protect
            if (wel_reg && !prot_hit(bp, addr_reg)) begin
              mem_we    <= 1'b1;
              mem_wdata <= rx_byte;
            end
            addr_reg <= addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
          end
          ST_READ: begin
            addr_reg <= addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
          end
          ST_WSTAT: begin
            // hardware guard: pin low plus guard bit blocks writes
            if (wel_reg && !(!wp_s &&
                status_reg[`SNV_ST_GUARD_BIT])) begin
              status_reg <= (rx_byte & `SNV_ST_WMASK) |
                            (status_reg & ~`SNV_ST_WMASK);
            end
            state_reg <= ST_IGNORE;
          end
          default: state_reg <= state_reg;             // status reads loop
        endcase
      end
      // output side: new bit on each falling edge, msb first; the
      // mode 3 leading fall lands outside a read phase and is ignored
      if (sck_fall && sending) begin
        if (bit_cnt_reg == 3'h0) begin
          so_out <= out_byte[7];
          tx_reg <= {out_byte[6:0], 1'b0};
        end else begin
          so_out <= tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

  // drive is armed from the first falling edge of a read phase;
  // a deselect seen during suspend waits until suspend ends
  always @(posedge clk) begin
    if (srst || (cs_s && hold_s)) begin
      so_oe_arm_reg <= 1'b0;
    end else if (sck_fall && sending) begin
      so_oe_arm_reg <= 1'b1;
    end
  end

  // array: read address tracks the current address each cycle
  snv_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (8),
    .DEPTH  (DEPTH)
  ) u_mem (
    .clk     (clk),
    .wr_en   (mem_we),
    .wr_addr (addr_reg - {{(ADDR_W-1){1'b0}}, 1'b1}),
    .wr_data (mem_wdata),
    .rd_addr (addr_reg),
    .rd_data (mem_rdata)
  );

endmodule // snv_spi_slave

`default_nettype wire

/* snv_spi_monitor.sv */
// assertion checker watching the spi slave pins
`timescale 1ns/1ns
`default_nettype none
module snv_spi_monitor (
  input wire logic       clk,        // system clock
  input wire logic       srst,       // sync reset, high
  input wire logic       cs_n,       // chip select, low active
  input wire logic       sck,        // serial clock pin
  input wire logic       wp_n,       // write protect, low active
  input wire logic       hold_n,     // suspend, low active
  input wire logic       so_out,     // serial out value
  input wire logic       so_oe,      // serial out enable
  input wire logic [7:0] status_out  // status byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // pins pass two sync flops, so levels must settle before we judge
  sequence s_desel; cs_n [*6]; endsequence
  sequence s_susp; !hold_n [*5]; endsequence
  sequence s_wp; !wp_n [*4]; endsequence
  property p_idle; s_desel |-> !so_oe; endproperty
  property p_quiet; s_desel |=> $stable(status_out); endproperty
  property p_edge; $changed(so_out) |-> !$past(sck, 3); endproperty
  property p_susp; s_susp |-> !so_oe; endproperty
  property p_frz;
    s_susp |=> $stable(status_out) && $stable(so_out);
  endproperty
  property p_guard;
    s_wp ##0 status_out[7] |=> status_out[7] && $stable(status_out[3:2]);
  endproperty
  property p_rise;
    $rose(so_oe) |-> !cs_n && hold_n && !$past(sck, 3);
  endproperty
  property p_rst; $fell(srst) |-> status_out == 8'h00 && !so_oe; endproperty
  a_idle: assert property (p_idle)
    else $error("output driven while deselected");
  a_quiet: assert property (p_quiet)
    else $error("status moved while deselected");
  a_edge: assert property (p_edge)
    else $error("output changed away from a clock fall");
  a_susp: assert property (p_susp)
    else $error("output driven during suspend");
  a_frz: assert property (p_frz)
    else $error("state moved during suspend");
  a_guard: assert property (p_guard)
    else $error("guarded status was rewritten");
  a_rise: assert property (p_rise)
    else $error("output enabled at the wrong moment");
  a_rst: assert property (p_rst)
    else $error("bad state after reset");
endmodule // snv_spi_monitor

bind snv_spi_slave snv_spi_monitor u_mon (.clk(clk), .srst(srst),
  .cs_n(cs_n), .sck(sck), .wp_n(wp_n), .hold_n(hold_n),
  .so_out(so_out), .so_oe(so_oe), .status_out(status_out));
`default_nettype wire

/* snv_spi_master.sv */
// spi bus master model, modes 0 and 3, 80 ns bit time
`timescale 1ns/1ns
`default_nettype none
module snv_spi_master (
  input  wire logic clk,    // bench clock, paces the bits
  output var  logic cs_n,   // chip select
  output var  logic sck,    // serial clock
  output var  logic si,     // data to device
  output var  logic hold_n, // suspend
  input  wire logic so_out, // device out value
  input  wire logic so_oe   // device out enable
);
  logic mode3 = 1'b0; // idle clock level, high for mode 3
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  // half bit, always launched just after a clock edge
  task automatic half; repeat (5) @(posedge clk); #1; endtask
  // every opcode gets its own falling select edge
  task automatic sel; sck = mode3; half; cs_n = 1'b0; half; endtask
  task automatic desel;
    half;
    sck = mode3;
    half;
    cs_n = 1'b1;
    si = ~si; // released line must not keep its old value
    half;
  endtask
  // one byte msb first; hb picks a bit to suspend
  task automatic xfer(input logic [7:0] tx, input int hb,
                      output logic [7:0] rx, output logic oe);
    oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0; // device shifts out here
      si = tx[i];
      if (i == hb) begin // hold moves only with clock low
        half;
        hold_n = 1'b0;
        half;
        sck = 1'b1;
        half;
        sck = 1'b0;
        half;
        hold_n = 1'b1;
      end
      half;
      sck = 1'b1; // device samples here
      // an undriven line reads as the inverse so a float is caught
      rx[i] = so_oe ? so_out : ~so_out;
      oe = oe | so_oe;
      half;
    end
  endtask
endmodule // snv_spi_master
`default_nettype wire

/* snv_spi_slave_tb.sv */
// self-checking bench for the spi slave
`timescale 1ns/1ns
`default_nettype none
`include "snv_defs.vh"
module snv_spi_slave_tb;
  logic       clk = 1'b0;  // 125 MHz
  logic       srst = 1'b1; // sync reset
  logic       wp_n = 1'b1; // write protect pin
  wire        cs_n, sck, si, hold_n, so_out, so_oe; // pins
  wire  [7:0] status_out;  // status byte
  int         fails = 0;      // mismatches
  int         num_checks = 0; // comparisons
  logic [7:0] got [0:4];   // bytes seen per frame
  logic       oe_any;      // output enabled in frame
  snv_spi_slave uut (.clk(clk), .srst(srst), .cs_n(cs_n), .sck(sck),
    .si(si), .so_out(so_out), .so_oe(so_oe), .wp_n(wp_n),
    .hold_n(hold_n), .status_out(status_out));
  snv_spi_master m (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe));
  initial begin forever #4 clk = ~clk; end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one selection: n bytes from the top of b
  task automatic run(input logic [39:0] b, input int n, input int hb);
    logic o;
    oe_any = 1'b0;
    m.sel;
    for (int k = 0; k < n; k++) begin
      m.xfer(b[39-8*k -: 8], (k == n-1) ? hb : -1, got[k], o);
      oe_any = oe_any | o;
    end
    m.desel;
  endtask
  task automatic wen; run({`SNV_CMD_WRITE_ENABLE, 32'h0}, 1, -1); endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d0, d1);
    run({`SNV_CMD_WRITE_ARRAY, a, d0, d1}, 5, -1);
  endtask
  task automatic rd(input logic [15:0] a, input int hb);
    run({`SNV_CMD_READ_ARRAY, a, 16'h0}, 5, hb);
  endtask
  task automatic wsr(input logic [7:0] v);
    wen;
    run({`SNV_CMD_WRITE_STATUS, v, 24'h0}, 2, -1);
  endtask
  // wrap at the top, ignored high address bits, back-to-back read
  task automatic t_rw;
    wen;
    chk(status_out & 8'h02, 8'h02);
    wr(16'hFFFF, 8'hA5, 8'h3C);
    chk(status_out & 8'h02, 8'h00);
    rd(16'h1FFF, -1);
    chk(got[3], 8'hA5);
    chk(got[4], 8'h3C);
    chk({7'h0, oe_any}, 8'h01);
    $display("t_rw done");
  endtask
  // no latch, then latch dropped by the disable command
  task automatic t_refuse;
    wen; wr(16'h0005, 8'h77, 8'h77);
    wr(16'h0005, 8'h11, 8'h11);
    wen; run({`SNV_CMD_WRITE_DISABLE, 32'h0}, 1, -1);
    chk(status_out & 8'h02, 8'h00);
    wr(16'h0005, 8'h22, 8'h22);
    rd(16'h0005, -1);
    chk(got[3], 8'h77);
    $display("t_refuse done");
  endtask
  // quarter protection splits one burst; whole array blocks all
  task automatic t_bp;
    wen; wr(16'h1800, 8'h11, 8'h11);
    wsr(8'h04);
    chk(status_out & 8'h8C, 8'h04);
    wen; wr(16'h17FF, 8'h22, 8'h33);
    rd(16'h17FF, -1);
    chk(got[3], 8'h22);
    chk(got[4], 8'h11);
    wsr(8'h0C);
    wen; wr(16'h0000, 8'h44, 8'h44);
    rd(16'h0000, -1);
    chk(got[3], 8'h3C);
    wsr(8'h00);
    $display("t_bp done");
  endtask
  // guard bit with the pin low blocks status writes
  task automatic t_wp;
    wsr(8'h80);
    wp_n = 1'b0;
    wsr(8'h0C);
    run({`SNV_CMD_READ_STATUS, 32'h0}, 2, -1);
    chk(got[1] & 8'h8C, 8'h80);
    wp_n = 1'b1;
    wsr(8'h00);
    chk(status_out & 8'h8C, 8'h00);
    $display("t_wp done");
  endtask
  // unknown opcode keeps output off; mode 3 read with a suspend
  task automatic t_bad_hold;
    run({8'hA5, 16'h1FFF, 16'h0}, 5, -1);
    chk({7'h0, oe_any}, 8'h00);
    m.mode3 = 1'b1;
    rd(16'h1FFF, 4);
    m.mode3 = 1'b0;
    chk(got[3], 8'hA5);
    chk(got[4], 8'h3C);
    $display("t_bad_hold done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge clk);
    chk(status_out, 8'h00);
    t_rw;
    t_refuse;
    t_bp;
    t_wp;
    t_bad_hold;
    end_of_test;
  end
  // about 60 frames of 5 bytes fit well inside this span
  initial begin
    #500000;
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test;
  end
endmodule // snv_spi_slave_tb
`default_nettype wire
